// file: design/csp_pkg.sv
package csp_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Register indices, byte address is four times the low index bits
   localparam logic [31:0] MODE_REG_IDX = 32'hfffffd20;
   localparam logic [31:0] CLKSEL_REG_IDX = 32'hfffffd21;
   localparam logic [31:0] TXBUF_REG_IDX = 32'hfffffd24;
   localparam logic [31:0] SHIFT_REG_IDX = 32'hfffffd28;

   // Byte address from an index
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [31:0] idx);
      byte_addr = {idx[5:0], 2'b00};
   endfunction

   // Mode register fields
   localparam int unsigned MODE_EN_BIT = 7;
   localparam int unsigned MODE_TRMD_BIT = 6;
   localparam int unsigned MODE_DIRC_BIT = 4;
   localparam int unsigned MODE_BUSY_BIT = 0;

   // Clock select fields
   localparam int unsigned CLK_CKP_BIT = 4;
   localparam int unsigned CLK_DAP_BIT = 3;
   localparam int unsigned CLK_CKS_LSB = 0;
   localparam int unsigned CLK_CKS_W = 3;

   // Reset values
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] CLKSEL_RESET = 8'h00;
   localparam logic [7:0] TXBUF_RESET = 8'h00;
   localparam logic [7:0] SHIFT_RESET = 8'h00;

   // Clock source codes
   localparam logic [2:0] CKS_BAUD = 3'h0;
   localparam logic [2:0] CKS_PLL1 = 3'h1;
   localparam logic [2:0] CKS_PLL0 = 3'h2;
   localparam logic [2:0] CKS_DIV32 = 3'h3;
   localparam logic [2:0] CKS_DIV64 = 3'h4;
   localparam logic [2:0] CKS_DIV128 = 3'h5;
   localparam logic [2:0] CKS_DIV512 = 3'h6;
   localparam logic [2:0] CKS_EXT = 3'h7;

   // Peripheral clock ratios and half-period masks
   localparam int unsigned DIV32 = 32;
   localparam int unsigned DIV64 = 64;
   localparam int unsigned DIV128 = 128;
   localparam int unsigned DIV512 = 512;
   localparam logic [7:0] MASK32 = 8'(DIV32 / 2 - 1);
   localparam logic [7:0] MASK64 = 8'(DIV64 / 2 - 1);
   localparam logic [7:0] MASK128 = 8'(DIV128 / 2 - 1);
   localparam logic [7:0] MASK512 = 8'(DIV512 / 2 - 1);

   // Bits per transfer
   localparam logic [3:0] BITS_PER_XFER = 4'h8;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic en;
      logic trmd;
      logic dirc;
   } csp_mode_t;

   typedef struct packed {
      logic ckp;
      logic dap;
      logic [CLK_CKS_W-1:0] cks;
   } csp_clksel_t;

endpackage

// file: design/csp_port.sv
`timescale 1ns/100ps
module csp_port (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [csp_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [csp_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [csp_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [csp_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe,
   output logic serial_data_out_pin,
   input wire logic serial_data_in_pin,
   input wire logic baud_rate_source,
   input wire logic pll_serial_clock_zero,
   input wire logic pll_serial_clock_one,
   output logic transfer_done_irq
);
   localparam logic [csp_pkg::ADDR_W-1:0] A_MODE = csp_pkg::byte_addr(csp_pkg::MODE_REG_IDX);
   localparam logic [csp_pkg::ADDR_W-1:0] A_CLK = csp_pkg::byte_addr(csp_pkg::CLKSEL_REG_IDX);
   localparam logic [csp_pkg::ADDR_W-1:0] A_TX = csp_pkg::byte_addr(csp_pkg::TXBUF_REG_IDX);
   localparam logic [csp_pkg::ADDR_W-1:0] A_SR = csp_pkg::byte_addr(csp_pkg::SHIFT_REG_IDX);

   csp_pkg::csp_mode_t mode_q;
   csp_pkg::csp_clksel_t clk_q;
   logic [7:0] txbuf_q;
   logic [7:0] sr_q;
   logic [3:0] cnt_q;
   logic busy_q;
   logic phase_q;
   logic done_q;
   logic so_q;
   logic sck_q;
   logic sck_oe_q;
   logic awready_q;
   logic wready_q;
   logic aw_hold_q;
   logic w_hold_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic [csp_pkg::ADDR_W-1:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic w_lane0_q;
   logic sck_s1_q;
   logic sck_s2_q;
   logic sck_s3_q;
   logic si_s1_q;
   logic si_s2_q;

   // Bus handshakes and decode
   wire aw_hs = s_axi_awvalid && awready_q;
   wire w_hs = s_axi_wvalid && wready_q;
   wire ar_hs = s_axi_arvalid && arready_q;
   wire wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   wire wr_go = wr_fire && w_lane0_q;
   wire wsel_mode = aw_addr_q == A_MODE;
   wire wsel_clk = aw_addr_q == A_CLK;
   wire wsel_tx = aw_addr_q == A_TX;
   wire wsel_sr = aw_addr_q == A_SR;
   wire wsel_ok = wsel_mode || wsel_clk || wsel_tx || wsel_sr;
   wire rsel_sr = s_axi_araddr == A_SR;

   // Transfer starts
   wire idle_en = mode_q.en && !busy_q;
   wire start_tx = wr_go && wsel_tx && idle_en && mode_q.trmd;
   wire start_rx = ar_hs && rsel_sr && idle_en && !mode_q.trmd;
   wire start = start_tx || start_rx;
   wire [7:0] load_w = start_tx ? w_data_q : sr_q;

   // Serial clock source and edges
   wire slave = clk_q.cks == csp_pkg::CKS_EXT;
   wire idle_lvl = !clk_q.ckp || slave;
   wire tick;
   wire sck_edge = sck_s2_q != sck_s3_q;
   wire lead_ev = busy_q && (slave ? (sck_edge && sck_s2_q == clk_q.ckp) : (tick && !phase_q));
   wire trail_ev = busy_q && (slave ? (sck_edge && sck_s2_q != clk_q.ckp) : (tick && phase_q));
   wire sample_ev = clk_q.dap ? lead_ev : trail_ev;
   wire launch_ev = clk_q.dap ? trail_ev : lead_ev;
   wire [3:0] cnt_n = cnt_q + {3'h0, sample_ev};
   wire end_ev = trail_ev && cnt_n == csp_pkg::BITS_PER_XFER;

   function automatic logic out_bit(input logic [7:0] v, input logic lsb_first);
      out_bit = lsb_first ? v[0] : v[7];
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                          input logic lsb_first);
      shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
   endfunction

   // Read data selection
   logic [31:0] rd_w;
   logic rd_ok;
   always_comb begin
      rd_w = 32'h0000_0000;
      rd_ok = 1'b1;
      if (s_axi_araddr == A_MODE) begin
         rd_w[csp_pkg::MODE_EN_BIT] = mode_q.en;
         rd_w[csp_pkg::MODE_TRMD_BIT] = mode_q.trmd;
         rd_w[csp_pkg::MODE_DIRC_BIT] = mode_q.dirc;
         rd_w[csp_pkg::MODE_BUSY_BIT] = busy_q;
      end else if (s_axi_araddr == A_CLK) begin
         rd_w[csp_pkg::CLK_CKP_BIT] = clk_q.ckp;
         rd_w[csp_pkg::CLK_DAP_BIT] = clk_q.dap;
         rd_w[csp_pkg::CLK_CKS_LSB +: csp_pkg::CLK_CKS_W] = clk_q.cks;
      end else if (s_axi_araddr == A_TX) begin
         rd_w[7:0] = txbuf_q;
      end else if (rsel_sr) begin
         rd_w[7:0] = sr_q;
      end else begin
         rd_ok = 1'b0;
      end
   end

   // Next data-out level
   logic so_d;
   always_comb begin
      so_d = so_q;
      if (!mode_q.trmd) begin
         so_d = 1'b0;
      end else if (!mode_q.en) begin
         so_d = clk_q.dap ? out_bit(txbuf_q, mode_q.dirc) : 1'b0;
      end else if (start_tx) begin
         so_d = clk_q.dap ? out_bit(w_data_q, mode_q.dirc) : so_q;
      end else if (launch_ev && !end_ev) begin
         so_d = out_bit(sr_q, mode_q.dirc);
      end
   end

   // Next clock-out level
   logic sck_d;
   always_comb begin
      sck_d = idle_lvl;
      if (busy_q && !slave) begin
         sck_d = lead_ev ? !idle_lvl : (trail_ev ? idle_lvl : sck_q);
      end
   end

   csp_tick_gen u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(start),
      .cks(clk_q.cks),
      .baud_i(baud_rate_source),
      .pll0_i(pll_serial_clock_zero),
      .pll1_i(pll_serial_clock_one),
      .tick(tick)
   );

   // Pin synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sck_s1_q <= 1'b1;
         sck_s2_q <= 1'b1;
         sck_s3_q <= 1'b1;
         si_s1_q <= 1'b0;
         si_s2_q <= 1'b0;
      end else begin
         sck_s1_q <= serial_clock_pin_i;
         sck_s2_q <= sck_s1_q;
         sck_s3_q <= sck_s2_q;
         si_s1_q <= serial_data_in_pin;
         si_s2_q <= si_s1_q;
      end
   end

   // Write channel acceptance and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= csp_pkg::RESP_OKAY;
         aw_addr_q <= '0;
         w_data_q <= 8'h00;
         w_lane0_q <= 1'b0;
      end else begin
         if (aw_hs) begin
            aw_hold_q <= 1'b1;
            awready_q <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            w_hold_q <= 1'b1;
            wready_q <= 1'b0;
            w_data_q <= s_axi_wdata[7:0];
            w_lane0_q <= s_axi_wstrb[0];
         end
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wsel_ok ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
         end
         if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= csp_pkg::RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else if (ar_hs) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rdata_q <= rd_w;
         rresp_q <= rd_ok ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // Software-written registers; shift register is not writable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q <= csp_pkg::csp_mode_t'(3'h0);
         clk_q <= csp_pkg::csp_clksel_t'(5'h00);
         txbuf_q <= csp_pkg::TXBUF_RESET;
      end else if (wr_go) begin
         if (wsel_mode) begin
            mode_q.en <= w_data_q[csp_pkg::MODE_EN_BIT];
            mode_q.trmd <= w_data_q[csp_pkg::MODE_TRMD_BIT];
            mode_q.dirc <= w_data_q[csp_pkg::MODE_DIRC_BIT];
         end
         if (wsel_clk) begin
            clk_q.ckp <= w_data_q[csp_pkg::CLK_CKP_BIT];
            clk_q.dap <= w_data_q[csp_pkg::CLK_DAP_BIT];
            clk_q.cks <= w_data_q[csp_pkg::CLK_CKS_LSB +: csp_pkg::CLK_CKS_W];
         end
         if (wsel_tx) begin
            txbuf_q <= w_data_q;
         end
      end
   end

   // Transfer engine; disabled port holds it cleared
   always_ff @(posedge aclk) begin
      if (!aresetn || !mode_q.en) begin
         busy_q <= 1'b0;
         sr_q <= csp_pkg::SHIFT_RESET;
         cnt_q <= 4'h0;
         phase_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= end_ev;
         if (start) begin
            busy_q <= 1'b1;
            sr_q <= load_w;
            cnt_q <= 4'h0;
            phase_q <= 1'b0;
         end else if (busy_q) begin
            if (sample_ev) begin
               sr_q <= shift_in(sr_q, si_s2_q, mode_q.dirc);
            end
            cnt_q <= cnt_n;
            if (lead_ev) begin
               phase_q <= 1'b1;
            end else if (trail_ev) begin
               phase_q <= 1'b0;
            end
            if (end_ev) begin
               busy_q <= 1'b0;
            end
         end
      end
   end

   // Pin outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         so_q <= 1'b0;
         sck_q <= 1'b1;
         sck_oe_q <= 1'b1;
      end else begin
         so_q <= so_d;
         sck_q <= sck_d;
         sck_oe_q <= !slave;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rresp = rresp_q;
   assign s_axi_rdata = rdata_q;
   assign serial_clock_pin_o = sck_q;
   assign serial_clock_pin_oe = sck_oe_q;
   assign serial_data_out_pin = so_q;
   assign transfer_done_irq = done_q;

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_tx_starts_busy: assert property (start_tx |=> busy_q)
      else $error("tx write did not start transfer");
   a_read_no_start: assert property (ar_hs && rsel_sr && mode_q.trmd && !busy_q |=> !busy_q)
      else $error("read started transfer in tx/rx mode");
   a_rx_read_start: assert property (start_rx |=> busy_q && cnt_q == 4'h0)
      else $error("rx-only read did not start");
   a_done_ends_busy: assert property (done_q |-> !busy_q && $past(busy_q, 1))
      else $error("completion without busy clear");
   a_eight_samples: assert property (end_ev |-> cnt_q == (clk_q.dap ? csp_pkg::BITS_PER_XFER
      : csp_pkg::BITS_PER_XFER - 4'h1))
      else $error("byte ended without eight bits");
   a_busy_holds: assert property (busy_q && !end_ev && mode_q.en |=> busy_q)
      else $error("busy dropped mid byte");
   a_disable_clears: assert property (!mode_q.en |=> !busy_q && sr_q == 8'h00)
      else $error("disable did not clear engine");
   a_rx_so_low: assert property (!mode_q.trmd |=> !serial_data_out_pin)
      else $error("data out not low in rx-only");
   a_idle_clock: assert property (!mode_q.en |=> serial_clock_pin_o == $past(idle_lvl))
      else $error("idle clock level wrong");
   a_single_byte: assert property (done_q |-> !busy_q ##1 (busy_q == $past(start)))
      else $error("transfer restarted without request");
   a_dap_first_bit: assert property (start_tx && clk_q.dap
      |=> serial_data_out_pin == $past(out_bit(w_data_q, mode_q.dirc)))
      else $error("first bit not presented early");

   c_tx_done: cover property (start_tx ##[1:1000] done_q);
   c_rx_done: cover property (start_rx ##[1:1000] done_q);
   c_slave_edge: cover property (slave && busy_q && lead_ev);
   c_abort: cover property (busy_q ##1 !mode_q.en);
endmodule

// file: design/csp_tick_gen.sv
`timescale 1ns/100ps
// Half-period tick from the selected clock source
module csp_tick_gen (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic restart,
   input wire logic [2:0] cks,
   input wire logic baud_i,
   input wire logic pll0_i,
   input wire logic pll1_i,
   output logic tick
);
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic [2:0] prev_q;
   logic [7:0] div_q;
   logic [2:0] edge_w;

   // Two-stage synchronisers, then edge history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
         prev_q <= 3'h0;
      end else begin
         sync1_q <= {pll1_i, pll0_i, baud_i};
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // Free divider, realigned at each transfer start
   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   function automatic logic hit(input logic [7:0] cnt, input logic [7:0] mask);
      hit = (cnt & mask) == mask;
   endfunction

   // Any edge of an external source is one half period
   assign edge_w = sync2_q ^ prev_q;

   // Source selection
   always_comb begin
      tick = 1'b0;
      case (cks)
         csp_pkg::CKS_BAUD: tick = edge_w[0];
         csp_pkg::CKS_PLL0: tick = edge_w[1];
         csp_pkg::CKS_PLL1: tick = edge_w[2];
         csp_pkg::CKS_DIV32: tick = hit(div_q, csp_pkg::MASK32);
         csp_pkg::CKS_DIV64: tick = hit(div_q, csp_pkg::MASK64);
         csp_pkg::CKS_DIV128: tick = hit(div_q, csp_pkg::MASK128);
         csp_pkg::CKS_DIV512: tick = hit(div_q, csp_pkg::MASK512);
         default: tick = 1'b0;
      endcase
   end
endmodule

// file: test/csp_peer.sv
`timescale 1ns/100ps
// Serial peer: one byte each way per frame
module csp_peer (
   input wire logic sck,
   input wire logic sdo,
   output logic sck_drv,
   output logic sdi
);
   logic ckp = 1'b0, dap = 1'b0, lsb = 1'b0, on = 1'b0;
   logic [7:0] tx = 8'h00, rx = 8'h00;
   int k = 0, s = 0;
   initial sck_drv = 1'b1;
   initial sdi = 1'b0;
   // Outgoing bit i in the agreed order
   function automatic logic bit_of(input int i);
      return lsb ? tx[i] : tx[7 - i];
   endfunction
   // Agreed mode and byte; data phase 1 places the first bit now
   task automatic arm(input logic p, input logic d, input logic l, input logic [7:0] b);
      sck_drv = ~p;
      #1;
      ckp = p;
      dap = d;
      lsb = l;
      tx = b;
      k = 0;
      s = 0;
      if (d) begin
         sdi = bit_of(0);
         k = 1;
      end
      on = 1'b1;
   endtask
   // Clock one frame as master; the line stands still outside it
   task automatic frame(input int half);
      repeat (16) begin
         #(half);
         sck_drv = ~sck_drv;
      end
   endtask
   // Launch on one edge, sample on the other, release after the last bit
   always @(sck) begin
      if (on) begin
         if ((sck === ckp) ^ dap) begin
            if (k < 8) sdi = bit_of(k);
            k++;
         end else begin
            rx[lsb ? s : 7 - s] = sdo;
            s++;
            on = (s < 8);
            if (s == 8) #200 sdi = ~sdi;
         end
      end
   end
endmodule

// file: test/tb.sv
`timescale 1ns/100ps
// Bench: register access and serial frames over every clock code
module tb;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, src_q = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic baud = 1'b0, pll0 = 1'b0, pll1 = 1'b0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, sck_o, sck_oe, so, irq, psck, sdi, sck_w;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata;
   logic [7:0] d, tb_b, pb_b;
   logic p, dp, l;
   logic [7:0] regs [4] = '{8'h80, 8'h84, 8'h90, 8'ha0};
   logic [4:0] cfgs [3] = '{5'h10, 5'h17, 5'h05};
   int seed = 45640;
   int n_errors = 0, n_checks = 0, irqs = 0, edges = 0, so_hi = 0, i0, e0, s0;

   always #12.5 aclk = ~aclk;
   // Pin level from whichever side drives it
   assign sck_w = sck_oe ? sck_o : psck;

   csp_port dut_u (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe(sck_oe),
      .serial_data_out_pin(so), .serial_data_in_pin(sdi), .baud_rate_source(baud),
      .pll_serial_clock_zero(pll0), .pll_serial_clock_one(pll1), .transfer_done_irq(irq)
   );
   csp_peer peer_u (.sck(sck_w), .sdo(so), .sck_drv(psck), .sdi(sdi));

   // Source clocks for codes 0 to 2, each edge a half period
   always @(posedge aclk) begin
      src_q <= src_q + 8'h01;
      baud <= src_q[4];
      pll0 <= src_q[3];
      pll1 <= src_q[5];
   end
   // Completion pulses and data-out highs
   always @(posedge aclk) begin
      if (irq === 1'b1) irqs++;
      if (so === 1'b1) so_hi++;
   end
   always @(sck_w) edges++;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (n_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   // One read; data and response land in d and r
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata[7:0];
      r = rresp;
      rready <= 1'b0;
   endtask
   function automatic logic [7:0] mode_x(input logic t, input logic l, input logic b);
      return {1'b1, t, 1'b0, l, 3'h0, b};
   endfunction
   function automatic logic sck_x(input logic [4:0] c);
      return !c[4] || c[2:0] == 3'h7;
   endfunction
   // One frame: configure while disabled, start, wait, check both ends
   task automatic xfer(input logic [2:0] c, input logic t);
      int n;
      p = 1'($random(seed));
      dp = 1'($random(seed));
      l = 1'($random(seed));
      tb_b = 8'($random(seed));
      pb_b = 8'($random(seed));
      wr(8'h80, 8'h00);
      wr(8'h84, {3'h0, p, dp, c});
      rd(8'h84);
      chk("clock_select", d, {3'h0, p, dp, c});
      chk("sck_drive", sck_oe, c != 3'h7);
      wr(8'h80, mode_x(t, l, 1'b0));
      peer_u.arm(p, dp, l, pb_b);
      e0 = edges;
      i0 = irqs;
      s0 = so_hi;
      if (t) wr(8'h90, tb_b);
      else rd(8'ha0);
      rd(8'h80);
      chk("busy_set", d, mode_x(t, l, 1'b1));
      if (c == 3'h7) peer_u.frame(400);
      n = 0;
      while (irqs == i0 && n < 9000) begin
         @(posedge aclk);
         n++;
      end
      chk("done_wait", n < 9000, 1);
      rd(8'h80);
      chk("busy_clear", d, mode_x(t, l, 1'b0));
      chk("edge_count", edges - e0, 16);
      chk("peer_rx", peer_u.rx, t ? tb_b : 8'h00);
      chk("so_low", t ? 0 : so_hi - s0, 0);
      repeat (600) @(posedge aclk);
      chk("one_done", irqs - i0, 1);
      rd(8'ha0);
      chk("shift_rx", d, pb_b);
      rd(8'h80);
      chk("read_start", d[0], !t);
   endtask

   // Hang guard
   initial begin
      #2000000;
      n_errors++;
      wrap_up();
   end

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("reset_pins", {sck_o, sck_oe, so, irq}, 4'hc);
      foreach (regs[i]) begin
         rd(regs[i]);
         chk("reset_value", d, 8'h00);
      end
      // Unmapped and read-only places
      wr(8'hfc, 8'h55);
      chk("bad_wr", r, 2'h2);
      rd(8'hfc);
      chk("bad_rd", {r, d}, 10'h200);
      wr(8'ha0, 8'hff);
      rd(8'ha0);
      chk("shift_ro", {r, d}, 10'h000);
      // Write with lane 0 off leaves the buffer alone
      wstrb <= 4'h0;
      wr(8'h90, 8'h5a);
      wstrb <= 4'hf;
      rd(8'h90);
      chk("lane0_off", {r, d}, 10'h000);
      // Disabled clock level per polarity and source
      foreach (cfgs[i]) begin
         wr(8'h84, {3'h0, cfgs[i]});
         repeat (2) @(posedge aclk);
         chk("sck_idle", sck_o, sck_x(cfgs[i]));
      end
      // Disabled data level
      tb_b = 8'($random(seed));
      wr(8'h90, tb_b);
      wr(8'h84, 8'h08);
      wr(8'h80, 8'h40);
      repeat (2) @(posedge aclk);
      chk("so_msb", so, tb_b[7]);
      wr(8'h80, 8'h50);
      repeat (2) @(posedge aclk);
      chk("so_lsb", so, tb_b[0]);
      wr(8'h80, 8'h10);
      repeat (2) @(posedge aclk);
      chk("so_rx_only", so, 1'b0);
      rd(8'h90);
      chk("txbuf", d, tb_b);
      rd(8'h80);
      chk("no_start", d, 8'h10);
      for (int c = 0; c < 8; c++) xfer(3'(c), 1'b1);
      xfer(3'h3, 1'b0);
      xfer(3'h7, 1'b0);
      // Disable in mid-frame
      wr(8'h80, 8'h00);
      wr(8'h84, 8'h03);
      wr(8'h80, 8'hc0);
      peer_u.arm(1'b0, 1'b0, 1'b0, 8'h5a);
      i0 = irqs;
      wr(8'h90, 8'h3c);
      repeat (100) @(posedge aclk);
      wr(8'h80, 8'h00);
      rd(8'h80);
      chk("abort_busy", d, 8'h00);
      rd(8'ha0);
      chk("abort_shift", d, 8'h00);
      repeat (600) @(posedge aclk);
      chk("abort_done", irqs - i0, 0);
      wrap_up();
   end
endmodule
